/* hdl/ssfc_codec.sv */
// generator-side encoder of sub-channel, FEC and service fields
`timescale 1ns/1ps
`default_nettype none
`include "ssfc_regs.svh"
module ssfc_codec
   import ssfc_pkg::*;
(
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RESET,
   // record request
   input  wire logic        REQ_VALID,
   output logic             REQ_READY,
   input  wire logic [1:0]  REQ_KIND,
   output logic             REQ_REJECT,
   // sub-channel and FEC fields
   input  wire logic [5:0]  SUBCH_NUM,
   input  wire logic [9:0]  START_ADDR,
   input  wire logic        LONG_FORM,
   input  wire logic        TABLE_SEL,
   input  wire logic [5:0]  TABLE_INDEX,
   input  wire logic [2:0]  OPTION,
   input  wire logic [1:0]  PROT_LEVEL,
   input  wire logic [9:0]  SUBCH_SIZE,
   input  wire logic        CARRIES_PACKET,
   input  wire logic [1:0]  FEC_SCHEME,
   // service fields
   input  wire logic        LONG_SID,
   input  wire logic [7:0]  EXT_COUNTRY,
   input  wire logic [3:0]  COUNTRY_CODE,
   input  wire logic [19:0] SERVICE_REF,
   input  wire logic        ACCESS_USED,
   input  wire logic [2:0]  ACCESS_SYSTEM_CODE,
   input  wire logic [3:0]  COMP_COUNT,
   // component descriptions
   input  wire logic        COMP_VALID,
   output logic             COMP_READY,
   input  wire logic [1:0]  COMP_TRANSPORT,
   input  wire logic [5:0]  COMP_TYPE,
   input  wire logic [5:0]  COMP_SUBCH,
   input  wire logic        COMP_PRIMARY,
   input  wire logic        COMP_ACCESS,
   input  wire logic [11:0] COMP_ENSEMBLE_NUM,
   output logic             COMP_REJECT,
   // byte stream
   output logic [7:0]       BYTE_DATA,
   output logic             BYTE_VALID,
   input  wire logic        BYTE_READY,
   output logic             BYTE_LAST,
   output logic [4:0]       FIELD_LEN,
   // status
   output logic [9:0]       INFO_SIZE_CU,
   output logic [2:0]       INFO_LEVEL,
   output logic             INFO_LEVEL_B,
   output logic [10:0]      INFO_RATE_KBPS,
   output logic             FEC_OWED
);
   // units per rate step; 1 on reserved options keeps the divider defined
   function automatic logic [4:0] cu_step(logic [2:0] opt,
                                          logic [1:0] lvl);
      logic [4:0] r;
      r = 5'd1;
      if (opt == `SSFC_OPT_A)
      begin
         unique case (lvl)
            2'd0: r = `SSFC_CU_A1;
            2'd1: r = `SSFC_CU_A2;
            2'd2: r = `SSFC_CU_A3;
            2'd3: r = `SSFC_CU_A4;
         endcase
      end
      else if (opt == `SSFC_OPT_B)
      begin
         unique case (lvl)
            2'd0: r = `SSFC_CU_B1;
            2'd1: r = `SSFC_CU_B2;
            2'd2: r = `SSFC_CU_B3;
            2'd3: r = `SSFC_CU_B4;
         endcase
      end
      return r;
   endfunction

   ssfc_state_e state_q, state_d;
   logic [39:0] sh_q, sh_d;
   logic [2:0]  cnt_q, cnt_d;
   logic [3:0]  left_q, left_d;
   logic [63:0] owed_q, owed_d;
   logic        rej_q, rej_d, crej_q, crej_d;
   logic [4:0]  len_q, len_d;
   logic [9:0]  isz_q, isz_d;
   logic [2:0]  ilv_q, ilv_d;
   logic        ilb_q, ilb_d;
   logic [10:0] irt_q, irt_d;

   logic [39:0] rec;
   logic [15:0] crec;
   logic [2:0]  nb;
   logic        ok, cok;
   logic [2:0]  acs;
   logic [4:0]  step;
   logic [9:0]  n_steps;
   logic [9:0]  t_size;
   logic [2:0]  t_level;
   logic [8:0]  t_rate;

   ssfc_short_table u_table (
      .idx       (TABLE_INDEX),
      .size_cu   (t_size),
      .level     (t_level),
      .rate_kbps (t_rate)
   );

   assign step    = cu_step(OPTION, PROT_LEVEL);
   assign n_steps = SUBCH_SIZE / {5'd0, step};
   // no access system in use forces the code to zero
   assign acs = ACCESS_USED ? ACCESS_SYSTEM_CODE : `SSFC_ACS_NONE;

   // request record, left-justified, and its acceptance
   always_comb
   begin
      rec = '0;
      nb  = 3'd0;
      ok  = 1'b0;
      unique case (ssfc_kind_e'(REQ_KIND))
         SSFC_KIND_SUBCH:
         begin
            if (LONG_FORM == `SSFC_FORM_SHORT)
            begin
               ok  = (TABLE_SEL == `SSFC_TBL_STD) &&
                     (START_ADDR <= `SSFC_START_MAX);
               rec = {SUBCH_NUM, START_ADDR, `SSFC_FORM_SHORT, TABLE_SEL,
                      TABLE_INDEX, 16'h0000};
               nb  = `SSFC_BYTES_SHORT;
            end
            else
            begin
               ok  = ((OPTION == `SSFC_OPT_A) ||
                      (OPTION == `SSFC_OPT_B)) &&
                     (SUBCH_SIZE != 10'd0) &&
                     (SUBCH_SIZE <= `SSFC_SIZE_MAX) &&
                     (SUBCH_SIZE % {5'd0, step} == 10'd0) &&
                     (START_ADDR <= `SSFC_START_MAX);
               rec = {SUBCH_NUM, START_ADDR, `SSFC_FORM_LONG, OPTION,
                      PROT_LEVEL, SUBCH_SIZE, 8'h00};
               nb  = `SSFC_BYTES_LONG;
            end
         end
         SSFC_KIND_FEC:
         begin
            ok  = (FEC_SCHEME == `SSFC_FEC_NONE) ||
                  (FEC_SCHEME == `SSFC_FEC_PKT);
            rec = {SUBCH_NUM, FEC_SCHEME, 32'h0000_0000};
            nb  = `SSFC_BYTES_FEC;
         end
         SSFC_KIND_SERVICE:
         begin
            ok = (COMP_COUNT != 4'd0) &&
                 (COMP_COUNT <= (LONG_SID ? `SSFC_CNT_MAX_32
                                          : `SSFC_CNT_MAX_16));
            if (LONG_SID)
            begin
               rec = {EXT_COUNTRY, COUNTRY_CODE, SERVICE_REF, `SSFC_RFA,
                      acs, COMP_COUNT};
               nb  = `SSFC_BYTES_SVC32;
            end
            else
            begin
               rec = {COUNTRY_CODE, SERVICE_REF[11:0], `SSFC_RFA, acs,
                      COMP_COUNT, 16'h0000};
               nb  = `SSFC_BYTES_SVC16;
            end
         end
         default:
         begin
            ok = 1'b0;
         end
      endcase
   end

   // component description; layout follows the transport code
   always_comb
   begin
      crec = '0;
      cok  = 1'b1;
      unique case (ssfc_tm_e'(COMP_TRANSPORT))
         SSFC_TM_AUDIO, SSFC_TM_SDATA:
         begin
            crec = {COMP_TRANSPORT, COMP_TYPE, COMP_SUBCH, COMP_PRIMARY,
                    COMP_ACCESS};
         end
         SSFC_TM_PACKET:
         begin
            crec = {COMP_TRANSPORT, COMP_ENSEMBLE_NUM, COMP_PRIMARY,
                    COMP_ACCESS};
         end
         SSFC_TM_RSVD:
         begin
            cok = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      state_d = state_q;
      sh_d    = sh_q;
      cnt_d   = cnt_q;
      left_d  = left_q;
      owed_d  = owed_q;
      rej_d   = 1'b0;
      crej_d  = 1'b0;
      len_d   = len_q;
      isz_d   = isz_q;
      ilv_d   = ilv_q;
      ilb_d   = ilb_q;
      irt_d   = irt_q;
      unique case (state_q)
         SSFC_IDLE:
         begin
            if (REQ_VALID && !ok)
            begin
               rej_d = 1'b1;
            end
            else if (REQ_VALID)
            begin
               sh_d    = rec;
               cnt_d   = nb;
               state_d = SSFC_SEND;
               left_d  = 4'd0;
               len_d   = {2'b00, nb};
               if (ssfc_kind_e'(REQ_KIND) == SSFC_KIND_SERVICE)
               begin
                  left_d = COMP_COUNT;
                  len_d  = {2'b00, nb} + {COMP_COUNT, 1'b0};
               end
               if (ssfc_kind_e'(REQ_KIND) == SSFC_KIND_FEC)
               begin
                  owed_d[SUBCH_NUM] = 1'b0;
               end
               if (ssfc_kind_e'(REQ_KIND) == SSFC_KIND_SUBCH)
               begin
                  owed_d[SUBCH_NUM] = CARRIES_PACKET;
                  if (LONG_FORM == `SSFC_FORM_SHORT)
                  begin
                     isz_d = t_size;
                     ilv_d = t_level;
                     ilb_d = 1'b0;
                     irt_d = {2'b00, t_rate};
                  end
                  else
                  begin
                     isz_d = SUBCH_SIZE;
                     ilv_d = {1'b0, PROT_LEVEL} + 3'd1;
                     ilb_d = OPTION[0];
                     irt_d = 11'({1'b0, n_steps} *
                                 (OPTION[0] ? `SSFC_KBPS_B
                                            : `SSFC_KBPS_A));
                  end
               end
            end
         end
         SSFC_SEND:
         begin
            if (BYTE_READY)
            begin
               sh_d  = {sh_q[31:0], 8'h00};
               cnt_d = cnt_q - 3'd1;
               if (cnt_q == 3'd1)
               begin
                  // nothing else may enter until the service field ends
                  state_d = (left_q != 4'd0) ? SSFC_WAIT_COMP
                                             : SSFC_IDLE;
               end
            end
         end
         SSFC_WAIT_COMP:
         begin
            if (COMP_VALID && !cok)
            begin
               crej_d = 1'b1;
            end
            else if (COMP_VALID)
            begin
               sh_d    = {crec, 24'h00_0000};
               cnt_d   = `SSFC_BYTES_COMP;
               left_d  = left_q - 4'd1;
               state_d = SSFC_SEND;
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         state_q <= SSFC_IDLE;
         sh_q    <= '0;
         cnt_q   <= '0;
         left_q  <= '0;
         owed_q  <= '0;
         rej_q   <= 1'b0;
         crej_q  <= 1'b0;
         len_q   <= '0;
         isz_q   <= '0;
         ilv_q   <= '0;
         ilb_q   <= 1'b0;
         irt_q   <= '0;
      end
      else
      begin
         state_q <= state_d;
         sh_q    <= sh_d;
         cnt_q   <= cnt_d;
         left_q  <= left_d;
         owed_q  <= owed_d;
         rej_q   <= rej_d;
         crej_q  <= crej_d;
         len_q   <= len_d;
         isz_q   <= isz_d;
         ilv_q   <= ilv_d;
         ilb_q   <= ilb_d;
         irt_q   <= irt_d;
      end
   end

   assign REQ_READY      = (state_q == SSFC_IDLE);
   assign COMP_READY     = (state_q == SSFC_WAIT_COMP);
   assign BYTE_VALID     = (state_q == SSFC_SEND);
   assign BYTE_DATA      = sh_q[39:32];
   assign BYTE_LAST      = BYTE_VALID && (cnt_q == 3'd1) &&
                           (left_q == 4'd0);
   assign REQ_REJECT     = rej_q;
   assign COMP_REJECT    = crej_q;
   assign FIELD_LEN      = len_q;
   assign INFO_SIZE_CU   = isz_q;
   assign INFO_LEVEL     = ilv_q;
   assign INFO_LEVEL_B   = ilb_q;
   assign INFO_RATE_KBPS = irt_q;
   assign FEC_OWED       = |owed_q;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);

   logic take, take_sub, take_svc;
   assign take     = REQ_VALID && REQ_READY;
   assign take_sub = take && (ssfc_kind_e'(REQ_KIND) == SSFC_KIND_SUBCH);
   assign take_svc = take && (ssfc_kind_e'(REQ_KIND) == SSFC_KIND_SERVICE);

   chk_table_sel_rsvd: assert property (
      take_sub && !LONG_FORM && TABLE_SEL |=> REQ_REJECT && REQ_READY)
      else $error("reserved table selector accepted");
   chk_option_rsvd: assert property (
      take_sub && LONG_FORM && (OPTION > 3'd1) |=> REQ_REJECT)
      else $error("reserved option accepted");
   chk_size_zero: assert property (
      take_sub && LONG_FORM && (SUBCH_SIZE == 10'd0) |=> REQ_REJECT)
      else $error("zero size accepted");
   chk_level_map: assert property (
      take_sub && LONG_FORM && ok |=>
      INFO_LEVEL == {1'b0, $past(PROT_LEVEL)} + 3'd1 &&
      INFO_LEVEL_B == $past(OPTION[0]))
      else $error("protection level mapped wrongly");
   chk_rate_a1: assert property (
      take_sub && LONG_FORM && ok && OPTION == 3'd0 && PROT_LEVEL == 2'd0
      |=> 13'(INFO_RATE_KBPS) * 13'd3 == 13'(INFO_SIZE_CU) * 13'd2)
      else $error("level 1-A rate and size disagree");
   chk_rate_b4: assert property (
      take_sub && LONG_FORM && ok && OPTION == 3'd1 && PROT_LEVEL == 2'd3
      |=> 16'(INFO_RATE_KBPS) * 16'd15 == 16'(INFO_SIZE_CU) * 16'd32)
      else $error("level 4-B rate and size disagree");
   chk_fec_rsvd: assert property (
      take && REQ_KIND == SSFC_KIND_FEC && FEC_SCHEME[1] |=> REQ_REJECT)
      else $error("reserved scheme accepted");
   chk_fec_owed: assert property (
      take_sub && ok && CARRIES_PACKET |=> FEC_OWED ##1 FEC_OWED)
      else $error("packet subchannel not owed a scheme record");
   // shortest field: three header bytes, one wait, two component bytes
   chk_field_whole: assert property (
      take_svc && ok |=> !REQ_READY [*6])
      else $error("service field interrupted");
   chk_count_limit: assert property (
      take_svc && LONG_SID && (COMP_COUNT > 4'd11) |=> REQ_REJECT)
      else $error("too many components accepted");
   // short identifier puts the reserved bit at the top of the third byte
   chk_rfa_zero: assert property (
      take_svc && ok && !LONG_SID |=> BYTE_VALID && !sh_q[23])
      else $error("reserved addition bit set");
   chk_transport_rsvd: assert property (
      COMP_VALID && COMP_READY && COMP_TRANSPORT == 2'b10 |=>
      COMP_REJECT && COMP_READY)
      else $error("reserved transport accepted");
   chk_short_size: assert property (
      take_sub && ok && !LONG_FORM && TABLE_INDEX == 6'd63 |=>
      INFO_SIZE_CU == 10'd416 && INFO_LEVEL == 3'd1)
      else $error("short table entry wrong");

   cov_short_rec: cover property (take_sub && ok && !LONG_FORM);
   cov_long_b: cover property (take_sub && ok && LONG_FORM && OPTION[0]);
   cov_svc_done: cover property (take_svc && ok ##[1:60] BYTE_LAST);
endmodule // ssfc_codec
`default_nettype wire

/* hdl/ssfc_pkg.sv */
// types shared by the signalling codec
package ssfc_pkg;
   typedef enum logic [1:0] {
      SSFC_TM_AUDIO  = 2'b00,
      SSFC_TM_SDATA  = 2'b01,
      SSFC_TM_RSVD   = 2'b10,
      SSFC_TM_PACKET = 2'b11
   } ssfc_tm_e;
   typedef enum logic [1:0] {
      SSFC_KIND_SUBCH   = 2'b00,
      SSFC_KIND_FEC     = 2'b01,
      SSFC_KIND_SERVICE = 2'b10
   } ssfc_kind_e;
   typedef enum logic [1:0] {
      SSFC_IDLE,
      SSFC_SEND,
      SSFC_WAIT_COMP
   } ssfc_state_e;
endpackage

/* hdl/ssfc_regs.svh */
// field layout, limits and coding constants of the signalling codec
// Summary of operation
// - table selector 0 standard, 1 reserved
// - six-bit index picks one of 64
// - option codes 000 and 001 only defined
// - option 000 levels map to 1-A..4-A
// - A levels take 12n/8n/6n/4n units
// - long size 1..864, matches permitted rate
// - option 001 levels map to 1-B..4-B
// - B levels take 27n/21n/18n/15n units
// - FEC record: subchannel, scheme; 1x reserved
// - FEC record owed for packet subchannels
// - whole service field in one group
// - identifier width follows the length flag
// - identifier holds country code and reference
// - reserved addition bit sent as zero
// - access system code zero when unused
// - component count at most 12 or 11
// - transport code selects description layout
// - stream descriptions carry type and subchannel
// - primary flag one for primary component
// - stream data carries data component type
// - packet description carries ensemble component number
// - form flag 0 short, 1 long
// - record has subchannel number, start 0..863
// - short index decoded through fixed table
`ifndef SSFC_REGS_SVH
`define SSFC_REGS_SVH
`define SSFC_START_MAX    10'd863
`define SSFC_SIZE_MAX     10'd864
`define SSFC_CNT_MAX_16   4'd12
`define SSFC_CNT_MAX_32   4'd11
`define SSFC_OPT_A        3'b000
`define SSFC_OPT_B        3'b001
`define SSFC_TBL_STD      1'b0
`define SSFC_FORM_SHORT   1'b0
`define SSFC_FORM_LONG    1'b1
`define SSFC_FEC_NONE     2'b00
`define SSFC_FEC_PKT      2'b01
`define SSFC_RFA          1'b0
`define SSFC_ACS_NONE     3'h0
`define SSFC_CU_A1        5'd12
`define SSFC_CU_A2        5'd8
`define SSFC_CU_A3        5'd6
`define SSFC_CU_A4        5'd4
`define SSFC_CU_B1        5'd27
`define SSFC_CU_B2        5'd21
`define SSFC_CU_B3        5'd18
`define SSFC_CU_B4        5'd15
`define SSFC_KBPS_A       11'd8
`define SSFC_KBPS_B       11'd32
`define SSFC_BYTES_SHORT  3'd3
`define SSFC_BYTES_LONG   3'd4
`define SSFC_BYTES_FEC    3'd1
`define SSFC_BYTES_SVC16  3'd3
`define SSFC_BYTES_SVC32  3'd5
`define SSFC_BYTES_COMP   3'd2
`endif

/* hdl/ssfc_short_table.sv */
// fixed short-form size and protection lookup
`timescale 1ns/1ps
`default_nettype none
module ssfc_short_table
   import ssfc_pkg::*;
(
   // lookup
   input  wire logic [5:0] idx,
   output logic      [9:0] size_cu,
   output logic      [2:0] level,
   output logic      [8:0] rate_kbps
);
   localparam logic [9:0] SIZE [64] = '{
      10'd16, 10'd21, 10'd24, 10'd29, 10'd35, 10'd24, 10'd29, 10'd35,
      10'd42, 10'd52, 10'd29, 10'd35, 10'd42, 10'd52, 10'd32, 10'd42,
      10'd48, 10'd58, 10'd70, 10'd40, 10'd52, 10'd58, 10'd70, 10'd84,
      10'd48, 10'd58, 10'd70, 10'd84, 10'd104, 10'd58, 10'd70, 10'd84,
      10'd104, 10'd64, 10'd84, 10'd96, 10'd116, 10'd140, 10'd80,
      10'd104, 10'd116, 10'd140, 10'd168, 10'd96, 10'd116, 10'd140,
      10'd168, 10'd208, 10'd116, 10'd140, 10'd168, 10'd208, 10'd232,
      10'd128, 10'd168, 10'd192, 10'd232, 10'd280, 10'd160, 10'd208,
      10'd280, 10'd192, 10'd280, 10'd416};
   localparam logic [2:0] LEVEL [64] = '{
      3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1,
      3'd5, 3'd4, 3'd3, 3'd2, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd5,
      3'd4, 3'd3, 3'd2, 3'd1, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd5,
      3'd4, 3'd3, 3'd2, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd5, 3'd4,
      3'd3, 3'd2, 3'd1, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd5, 3'd4,
      3'd3, 3'd2, 3'd1, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd5, 3'd4,
      3'd2, 3'd5, 3'd3, 3'd1};
   // rate groups: first index of each group and its rate
   localparam logic [5:0] GRP_START [14] = '{
      6'd0, 6'd5, 6'd10, 6'd14, 6'd19, 6'd24, 6'd29, 6'd33, 6'd38,
      6'd43, 6'd48, 6'd53, 6'd58, 6'd61};
   localparam logic [8:0] GRP_RATE [14] = '{
      9'd32, 9'd48, 9'd56, 9'd64, 9'd80, 9'd96, 9'd112, 9'd128, 9'd160,
      9'd192, 9'd224, 9'd256, 9'd320, 9'd384};

   always_comb
   begin
      size_cu   = SIZE[idx];
      level     = LEVEL[idx];
      rate_kbps = GRP_RATE[0];
      for (int g = 1; g < 14; g++)
      begin
         if (idx >= GRP_START[g])
         begin
            rate_kbps = GRP_RATE[g];
         end
      end
   end
endmodule // ssfc_short_table
`default_nettype wire

/* testbench/ssfc_sink.sv */
// receiver-side byte sink of the signalling codec
`timescale 1ns/1ps
`default_nettype none
module ssfc_sink
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // byte stream
   input  wire logic [7:0] byte_data,
   input  wire logic       byte_valid,
   input  wire logic       byte_last,
   output logic            byte_ready
);
   logic [8:0] got[$];
   initial byte_ready = 1'b0;
   // random stalls keep the codec's hold path busy
   always @(posedge clk)
   begin
      byte_ready <= !rst && ($urandom % 4 != 0);
      if (!rst && byte_valid && byte_ready)
         got.push_back({byte_last, byte_data});
   end
endmodule // ssfc_sink
`default_nettype wire

/* testbench/tb_subchannel_service_field_codec.sv */
// self-checking bench of the signalling codec
`timescale 1ns/1ps
`default_nettype none
module tb_subchannel_service_field_codec
   import ssfc_pkg::*;
;
   logic        ref_clk = 0, reset = 1, req_valid = 0, long_form = 0;
   logic        table_sel = 0, carries_packet = 0, long_sid = 0;
   logic        access_used = 0, comp_valid = 0, comp_primary = 0;
   logic        comp_access = 0;
   logic [1:0]  req_kind = 0, prot_level = 0, fec_scheme = 0;
   logic [1:0]  comp_transport = 0;
   logic [2:0]  option = 0, access_system_code = 0, info_level;
   logic [3:0]  country_code = 0, comp_count = 0;
   logic [5:0]  subch_num = 0, table_index = 0, comp_type = 0;
   logic [5:0]  comp_subch = 0;
   logic [7:0]  ext_country = 0, byte_data;
   logic [9:0]  start_addr = 0, subch_size = 0, info_size_cu;
   logic [11:0] comp_ensemble_num = 0;
   logic [19:0] service_ref = 0;
   logic        req_ready, req_reject, comp_ready, comp_reject;
   logic        byte_valid, byte_ready, byte_last, info_level_b, fec_owed;
   logic [4:0]  field_len;
   logic [10:0] info_rate_kbps;
   logic [63:0] owm = 0;
   logic [8:0]  exq[$];
   int          fails = 0, compares = 0;
   int          sa[4] = '{12, 8, 6, 4}, sb[4] = '{27, 21, 18, 15};

   ssfc_codec u_ssfc_codec (
      .REF_CLK(ref_clk), .RESET(reset), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ_KIND(req_kind), .REQ_REJECT(req_reject),
      .SUBCH_NUM(subch_num), .START_ADDR(start_addr),
      .LONG_FORM(long_form), .TABLE_SEL(table_sel),
      .TABLE_INDEX(table_index), .OPTION(option),
      .PROT_LEVEL(prot_level), .SUBCH_SIZE(subch_size),
      .CARRIES_PACKET(carries_packet), .FEC_SCHEME(fec_scheme),
      .LONG_SID(long_sid), .EXT_COUNTRY(ext_country),
      .COUNTRY_CODE(country_code), .SERVICE_REF(service_ref),
      .ACCESS_USED(access_used), .ACCESS_SYSTEM_CODE(access_system_code),
      .COMP_COUNT(comp_count), .COMP_VALID(comp_valid),
      .COMP_READY(comp_ready), .COMP_TRANSPORT(comp_transport),
      .COMP_TYPE(comp_type), .COMP_SUBCH(comp_subch),
      .COMP_PRIMARY(comp_primary), .COMP_ACCESS(comp_access),
      .COMP_ENSEMBLE_NUM(comp_ensemble_num), .COMP_REJECT(comp_reject),
      .BYTE_DATA(byte_data), .BYTE_VALID(byte_valid),
      .BYTE_READY(byte_ready), .BYTE_LAST(byte_last),
      .FIELD_LEN(field_len), .INFO_SIZE_CU(info_size_cu),
      .INFO_LEVEL(info_level), .INFO_LEVEL_B(info_level_b),
      .INFO_RATE_KBPS(info_rate_kbps), .FEC_OWED(fec_owed)
   );

   ssfc_sink u_ssfc_sink (
      .clk(ref_clk), .rst(reset), .byte_data(byte_data),
      .byte_valid(byte_valid), .byte_last(byte_last),
      .byte_ready(byte_ready)
   );

   initial
   begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("CHECK FAILED %0t %h %h", $time, s, e);
      end
   endtask

   task automatic complete_run();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // sampled mid-cycle so the launching edge has settled
   task automatic wt(ref logic r);
      int n = 0;
      @(negedge ref_clk);
      while (r !== 1'b1 && n++ < 900)
         @(negedge ref_clk);
   endtask

   task automatic put(input logic [39:0] v, input int n, input bit f);
      for (int i = n - 1; i >= 0; i--)
         exq.push_back({f && i == 0, v[8*i +: 8]});
   endtask

   task automatic offer(input logic [1:0] k, input bit rej);
      req_kind <= k;
      req_valid <= 1'b1;
      wt(req_ready);
      @(posedge ref_clk);
      req_valid <= 1'b0;
      @(negedge ref_clk);
      chk(req_reject, rej);
      @(posedge ref_clk);
   endtask

   task automatic settle(input int len);
      wt(req_ready);
      chk(field_len, len);
      chk(u_ssfc_sink.got.size(), exq.size());
      while (exq.size() > 0 && u_ssfc_sink.got.size() > 0)
         chk(u_ssfc_sink.got.pop_front(), exq.pop_front());
      exq.delete();
      u_ssfc_sink.got.delete();
      @(posedge ref_clk);
   endtask

   task automatic sub(input bit lg, ts, input logic [9:0] st,
         input logic [5:0] ix, input logic [2:0] op, input logic [1:0] lv,
         input logic [9:0] sz, input bit rej, input logic [6:0] r);
      int p;
      p = op[0] ? sb[lv] : sa[lv];
      subch_num <= r[5:0];
      start_addr <= st;
      long_form <= lg;
      table_sel <= ts;
      table_index <= ix;
      option <= op;
      prot_level <= lv;
      subch_size <= sz;
      carries_packet <= r[6];
      offer(2'b00, rej);
      if (rej)
         return;
      owm[r[5:0]] = r[6];
      if (lg)
         put({r[5:0], st, 1'b1, op, lv, sz}, 4, 1);
      else
         put({r[5:0], st, 1'b0, ts, ix}, 3, 1);
      settle(lg ? 4 : 3);
      chk(fec_owed, |owm);
      if (lg)
      begin
         chk(info_size_cu, sz);
         chk(info_level, lv + 1);
         chk(info_level_b, op[0]);
         chk(info_rate_kbps, sz / p * (op[0] ? 32 : 8));
      end
   endtask

   task automatic svc(input bit lg, input logic [3:0] c, input bit rej);
      logic [39:0] r;
      logic [13:0] q;
      logic [1:0]  t;
      int          m;
      m = c;
      r = {8'($urandom), $urandom};
      long_sid <= lg;
      ext_country <= r[39:32];
      country_code <= r[31:28];
      service_ref <= r[27:8];
      access_used <= r[7];
      access_system_code <= r[6:4];
      comp_count <= c;
      offer(2'b10, rej);
      if (rej)
         return;
      r[6:4] = r[7] ? r[6:4] : 3'h0;
      if (lg)
         put({r[39:8], 1'b0, r[6:4], c}, 5, 0);
      else
         put({r[31:28], r[19:8], 1'b0, r[6:4], c}, 3, 0);
      // one reserved description first, then the counted good ones
      for (int i = -1; i < m; i++)
      begin
         q = 14'($urandom);
         t = i < 0 ? 2'b10 : i % 3 == 2 ? 2'b11 : 2'(i % 3);
         comp_transport <= t;
         comp_type <= q[5:0];
         comp_subch <= q[11:6];
         comp_ensemble_num <= q[11:0];
         comp_primary <= q[12];
         comp_access <= q[13];
         comp_valid <= 1'b1;
         wt(comp_ready);
         @(posedge ref_clk);
         comp_valid <= 1'b0;
         @(negedge ref_clk);
         chk(comp_reject, i < 0);
         @(posedge ref_clk);
         if (t == 2'b11)
            put({t, q[11:0], q[12], q[13]}, 2, i == m - 1);
         else if (i >= 0)
            put({t, q[5:0], q[11:6], q[12], q[13]}, 2, i == m - 1);
      end
      settle(lg ? 5 + 2 * m : 3 + 2 * m);
   endtask

   initial
   begin
      #200000;
      fails++;
      complete_run();
   end

   initial
   begin
      logic [5:0] v;
      int         s;
      void'($urandom(32));
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      sub(0, 0, 0, 0, 0, 0, 0, 0, 7'($urandom));
      chk(info_size_cu, 16);
      chk(info_level, 5);
      chk(info_rate_kbps, 32);
      sub(0, 0, 863, 63, 0, 0, 0, 0, 7'($urandom));
      chk(info_size_cu, 416);
      chk(info_rate_kbps, 384);
      sub(0, 1, 0, 5, 0, 0, 0, 1, 0);
      sub(0, 0, 864, 5, 0, 0, 0, 1, 0);
      for (int o = 0; o < 8; o++)
         for (int l = 0; l < 4; l++)
         begin
            s = o[0] ? sb[l] : sa[l];
            s = s * (l == 0 ? 864 / s : 1 + $urandom % (864 / s));
            sub(1, 0, 10'($urandom % 864), 0, 3'(o), 2'(l), 10'(s),
                o > 1, 7'($urandom));
         end
      sub(1, 0, 0, 0, 0, 0, 0, 1, 0);
      sub(1, 0, 0, 0, 0, 0, 10'd876, 1, 0);
      sub(1, 0, 0, 0, 1, 1, 10'd22, 1, 0);
      for (int k = 0; k < 4; k++)
      begin
         v = 6'($urandom);
         sub(0, 0, 0, 0, 0, 0, 0, 0, {1'b1, v});
         subch_num <= v;
         fec_scheme <= 2'(k);
         offer(2'b01, k > 1);
         if (k < 2)
         begin
            owm[v] = 1'b0;
            put({v, 2'(k)}, 1, 1);
            settle(1);
            chk(fec_owed, |owm);
         end
      end
      offer(2'b11, 1);
      svc(0, 12, 0);
      svc(0, 13, 1);
      svc(1, 11, 0);
      svc(1, 12, 1);
      svc(0, 0, 1);
      complete_run();
   end
endmodule // tb_subchannel_service_field_codec
`default_nettype wire
